// *** tb_wit_timer.sv ***
// Self-checking bench for the watchdog timer block.
// Assumes wit_cpu_model drives the bus; 60000-cycle ceiling.
`timescale 1ns/10ps
module tb_wit_timer;
  localparam logic [27:0] CW = wit_pkg::ADDR_CTRL_WR;
  localparam logic [27:0] CR = wit_pkg::ADDR_CTRL_RD;
  localparam logic [27:0] NR = wit_pkg::ADDR_COUNT_RD;
  localparam logic [27:0] RW = wit_pkg::ADDR_RST_WR;
  localparam logic [27:0] RR = wit_pkg::ADDR_RST_RD;
  logic clk_i;
  logic nrst_i = 1'b0;
  logic standby_entry_i = 1'b0;
  wit_pkg::wit_bus_req_s bus_req;
  wit_pkg::wit_bus_rsp_s bus_rsp;
  logic irq;
  logic ovf_n;
  wit_pkg::wit_chip_rst_s crst;
  int fails = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n;
  logic [7:0] q;
  int dv[8] = '{2, 64, 128, 256, 512, 1024, 4096, 8192};
  logic [7:0] rc[3] = '{8'h5F, 8'h7F, 8'h1F};
  wit_timer dut_u (.clk_i, .nrst_i, .standby_entry_i, .bus_req_i(bus_req),
    .bus_rsp_o(bus_rsp), .interval_irq_o(irq), .overflow_out_n_o(ovf_n),
    .chip_rst_o(crst));
  wit_cpu_model cpu_u (.clk_i, .bus_rsp_i(bus_rsp), .bus_req_o(bus_req));
  // Clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Hang guard
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      end_of_test();
    end
  end
  task chk(input string nm, input logic [9:0] e, input logic [9:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task rdc(input string nm, input logic [27:0] a, input logic [7:0] e);
    cpu_u.rd(a, q);
    chk(nm, e, q);
    chk("ack", 10'h001, bus_rsp.ack);
  endtask : rdc
  // Cycles until a signal reaches a level
  task wt(input logic lvl, input int lim, input bit pin);
    n = 0;
    while ((pin ? ovf_n : irq) !== lvl && n < lim) begin
      @(posedge clk_i);
      #1 n++;
    end
    if ((pin ? ovf_n : irq) !== lvl) begin
      fails++;
      $display("wrong value wait exp %0d got %0d", lvl, pin ? ovf_n : irq);
    end
  endtask : wt
  task end_of_test;
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  // Main sequence
  initial begin
    repeat (5) @(posedge clk_i);
    nrst_i <= 1'b1;
    rdc("ctrl", CR, 8'h18);
    rdc("count", NR, 8'h00);
    rdc("rstc", RR, 8'h1F);
    cpu_u.acc(1'b1, 1'b0, CW, 16'hA538, q);
    cpu_u.acc(1'b1, 1'b1, CW, 16'h3C38, q);
    cpu_u.acc(1'b1, 1'b0, RW, 16'h5A7F, q);
    cpu_u.acc(1'b0, 1'b1, CR, 16'h0000, q);
    chk("word read", 10'h000, q);
    rdc("ctrl", CR, 8'h18);
    rdc("rstc", RR, 8'h1F);
    for (int s = 0; s < 8; s++) begin
      cpu_u.wr(CW, {8'hA5, 5'h07, 3'(s)});
      cpu_u.wr(CW, 16'h5AFE);
      wt(1'b1, 20000, 1'b0);
      chk("tick", 10'h001, 10'(n > dv[s] && n <= 2 * dv[s]));
      chk("pin", 10'h001, ovf_n);
      cpu_u.wr(CW, {8'hA5, 5'h07, 3'(s)});
      chk("irq", 10'h001, irq);
      rdc("ctrl", CR, {5'h17, 3'(s)});
      cpu_u.wr(CW, {8'hA5, 5'h17, 3'(s)});
      rdc("ctrl", CR, {5'h17, 3'(s)});
      cpu_u.wr(CW, {8'hA5, 5'h03, 3'(s)});
      rdc("ctrl", CR, {5'h03, 3'(s)});
    end
    cpu_u.wr(CW, 16'h5A33);
    rdc("count", NR, 8'h00);
    for (int k = 0; k < 3; k++) begin
      cpu_u.wr(RW, {8'h5A, rc[k]});
      rdc("rstc", RR, rc[k]);
      cpu_u.wr(CW, 16'hA578);
      cpu_u.wr(CW, 16'h5AFE);
      wt(1'b0, 600, 1'b1);
      chk("por", 10'(rc[k] == 8'h5F), crst.power_on);
      chk("manual", 10'(rc[k] == 8'h7F), crst.manual);
      chk("irq", 10'h000, irq);
      wt(1'b1, 300, 1'b1);
      chk("pin low", 10'd128, 10'(n));
      rdc("ctrl", CR, 8'h18);
      cpu_u.wr(RW, 16'hA500);
      rdc("rstc", RR, rc[k] | 8'h80);
      cpu_u.wr(RW, 16'hA51F);
      rdc("rstc", RR, rc[k] | 8'h80);
      cpu_u.wr(RW, 16'hA500);
      rdc("rstc", RR, rc[k]);
      repeat (400) @(posedge clk_i);
    end
    cpu_u.wr(CW, 16'hA57B);
    cpu_u.wr(RW, 16'h5A7F);
    @(posedge clk_i) standby_entry_i <= 1'b1;
    @(posedge clk_i) standby_entry_i <= 1'b0;
    rdc("ctrl", CR, 8'h1B);
    rdc("rstc", RR, 8'h1F);
    // Pin reset in mid-run clears the select and reloads reset control
    cpu_u.wr(CW, 16'hA57B);
    cpu_u.wr(RW, 16'h5A7F);
    @(posedge clk_i) nrst_i <= 1'b0;
    @(posedge clk_i) nrst_i <= 1'b1;
    rdc("ctrl", CR, 8'h18);
    rdc("rstc", RR, 8'h1F);
    end_of_test();
  end
endmodule : tb_wit_timer

// *** wit_cpu_model.sv ***
// CPU bus master model for the watchdog timer block.
// Assumes one access at a time, synchronous to clk_i.
`timescale 1ns/10ps
module wit_cpu_model (
  // Clock
  input wire logic clk_i,
  // Peripheral bus
  input wire wit_pkg::wit_bus_rsp_s bus_rsp_i,
  output wit_pkg::wit_bus_req_s bus_req_o
);
  initial bus_req_o = '0;
  // One access; the bus is scrambled once released
  task automatic acc(input logic w, input logic wd,
    input logic [27:0] a, input logic [15:0] d, output logic [7:0] q);
    @(posedge clk_i);
    bus_req_o <= {1'b1, w, wd, a, d};
    @(posedge clk_i);
    bus_req_o <= {1'b0, ~w, ~wd, ~a, ~d};
    #1 q = bus_rsp_i.rdata;
  endtask : acc
  // Keyed word write
  task automatic wr(input logic [27:0] a, input logic [15:0] d);
    logic [7:0] q;
    acc(1'b1, 1'b1, a, d, q);
  endtask : wr
  // Byte read
  task automatic rd(input logic [27:0] a, output logic [7:0] q);
    acc(1'b0, 1'b0, a, 16'h0000, q);
  endtask : rd
endmodule : wit_cpu_model

// *** wit_pkg.sv ***
// Package for the watchdog and interval timer register block.
// Assumes one system clock and a CPU peripheral bus with
// byte and word transfers, all in the same clock domain.
package wit_pkg;

  // Bus address width and register addresses
  localparam int ADDR_W = 28;
  localparam logic [27:0] ADDR_CTRL_WR = 28'h5FFFFB8;
  localparam logic [27:0] ADDR_CTRL_RD = 28'h5FFFFB8;
  localparam logic [27:0] ADDR_COUNT_RD = 28'h5FFFFB9;
  localparam logic [27:0] ADDR_RST_WR = 28'h5FFFFBA;
  localparam logic [27:0] ADDR_RST_RD = 28'h5FFFFBB;

  // Write keys carried in the upper byte of a word write
  localparam logic [7:0] KEY_COUNT = 8'h5A;
  localparam logic [7:0] KEY_CTRL = 8'hA5;
  localparam logic [7:0] KEY_RST_CLR = 8'hA5;
  localparam logic [7:0] KEY_RST_CFG = 8'h5A;
  localparam logic [7:0] RST_CLR_DATA = 8'h00;

  // Field positions in the control and reset registers
  localparam int CTRL_FLAG_BIT = 7;
  localparam int CTRL_MODE_BIT = 6;
  localparam int CTRL_RUN_BIT = 5;
  localparam int CTRL_SEL_LSB = 0;
  localparam int RST_FLAG_BIT = 7;
  localparam int RST_ENA_BIT = 6;
  localparam int RST_TYPE_BIT = 5;

  // Reserved bits read as one; reset values
  localparam logic [7:0] CTRL_RESV_ONES = 8'h18;
  localparam logic [7:0] RST_RESV_ONES = 8'h1F;
  localparam logic [2:0] SEL_RESET = 3'h0;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COUNT_TOP = 8'hFF;

  // Pulse lengths in system clock cycles
  localparam int OVF_PULSE_CYCLES = 128;
  localparam int CHIP_RST_CYCLES = 512;

  // Prescaler width, enough for the divide by 8192 tap
  localparam int PRE_W = 13;

  // Counter overflow behaviour
  typedef enum logic {
    MODE_INTERVAL = 1'b0,
    MODE_WATCHDOG = 1'b1
  } wit_mode_e;

  // Request from the CPU peripheral bus
  typedef struct packed {
    logic valid;
    logic write;
    logic word;
    logic [27:0] addr;
    logic [15:0] wdata;
  } wit_bus_req_s;

  // Answer to the CPU peripheral bus
  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
  } wit_bus_rsp_s;

  // Internal chip reset requests
  typedef struct packed {
    logic power_on;
    logic manual;
  } wit_chip_rst_s;

endpackage : wit_pkg

// *** wit_timer.sv ***
// Watchdog and interval timer with keyed register writes.
// Assumes the bus request is synchronous to clk_i, that
// standby_entry_i is a one-cycle pulse from the power
// controller, and that nrst_i is the external reset pin.
`timescale 1ns/10ps

// Function
// - Reset or standby clears flag, mode, run; select survives standby only.
// - Interval mode wrap from all ones to zero sets interval flag.
// - Interval flag clears on reset, standby, or read-as-one then zero write.
// - Interval mode raises interrupt; watchdog mode drives overflow pin.
// - Run bit low holds counter at zero; high lets it count.
// - Reserved bits read as one; software writes ones there.
// - Select picks divide by 2,64,128,256,512,1024,4096,8192.
// - Reset-control register loads 1F on pin reset and standby only.
// - Watchdog mode wrap sets watchdog flag, never in interval mode.
// - Watchdog flag clears on reset, standby, or read-as-one then keyed zero write.
// - Watchdog wrap with enable issues chip reset; counter, control reset. Interval flag is kept through the wrap.
// - Reset type zero gives power-on reset, one gives manual reset.
// - Counter and control register take word writes only.
// - Shared write address: key 5A loads counter, A5 loads control.
// - Reset-control register written only by word at its address.
// - Key A5 with data 00 clears watchdog flag only.
// - Key 5A copies data bits 6 and 5 to enable and type.
// - Counter is eight-bit up-counter on prescaled ticks, wrapping.
// - Byte reads: control B8, counter B9, reset-control BB.
// - Watchdog wrap drives overflow pin low for 128 cycles.
// - Chip reset stays asserted for 512 cycles.
module wit_timer (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Power management
  input wire logic standby_entry_i,
  // Peripheral bus
  input wire wit_pkg::wit_bus_req_s bus_req_i,
  output wit_pkg::wit_bus_rsp_s bus_rsp_o,
  // Events
  output logic interval_irq_o,
  output logic overflow_out_n_o,
  output wit_pkg::wit_chip_rst_s chip_rst_o
);

  // Divider mask for the selected tap: divide value minus one
  function automatic logic [12:0] tap_mask(input logic [2:0] sel);
    logic [12:0] m;
    m = 13'h0001;
    case (sel)
      3'h0: m = 13'h0001;
      3'h1: m = 13'h003F;
      3'h2: m = 13'h007F;
      3'h3: m = 13'h00FF;
      3'h4: m = 13'h01FF;
      3'h5: m = 13'h03FF;
      3'h6: m = 13'h0FFF;
      default: m = 13'h1FFF;
    endcase
    return m;
  endfunction : tap_mask

  // Control register fields
  logic interval_overflow_flag_ff;
  wit_pkg::wit_mode_e timer_mode_select_ff;
  logic timer_run_enable_ff;
  logic [2:0] prescale_select_ff;
  logic ovf_armed_ff;

  // Counter and prescaler
  logic [7:0] timer_count_ff;
  logic [12:0] pre_ff;

  // Reset control register fields
  logic watchdog_overflow_flag_ff;
  logic chip_reset_enable_ff;
  logic chip_reset_type_ff;
  logic watchdog_overflow_flag_armed_ff;

  // Output pulse timers
  logic ovo_n_ff;
  logic [6:0] ovo_cnt_ff;
  wit_pkg::wit_chip_rst_s crst_ff;
  logic [8:0] crst_cnt_ff;
  wit_pkg::wit_bus_rsp_s rsp_ff;

  // Decoded accesses
  logic wr_word;
  logic rd_byte;
  logic [7:0] wr_hi;
  logic [7:0] wr_lo;
  logic wr_shared;
  logic wr_rst;
  logic cnt_load;
  logic ctrl_load;
  logic rst_clr;
  logic rst_cfg;
  logic rd_ctrl;
  logic rd_count;
  logic rd_rst;
  logic tick;
  logic wrap;
  logic iv_wrap;
  logic wd_wrap;
  logic [7:0] nxt_rdata;

  // Bus decoding; byte writes never reach the registers
  assign wr_word = bus_req_i.valid & bus_req_i.write
                 & bus_req_i.word;
  assign rd_byte = bus_req_i.valid & ~bus_req_i.write
                 & ~bus_req_i.word;
  assign wr_hi = bus_req_i.wdata[15:8];
  assign wr_lo = bus_req_i.wdata[7:0];
  assign wr_shared = wr_word
                   & (bus_req_i.addr == wit_pkg::ADDR_CTRL_WR);
  assign wr_rst = wr_word
                & (bus_req_i.addr == wit_pkg::ADDR_RST_WR);

  // Keyed write selection; other keys match nothing
  assign cnt_load = wr_shared
                  & (wr_hi == wit_pkg::KEY_COUNT);
  assign ctrl_load = wr_shared
                   & (wr_hi == wit_pkg::KEY_CTRL);
  assign rst_clr = wr_rst & (wr_hi == wit_pkg::KEY_RST_CLR)
                 & (wr_lo == wit_pkg::RST_CLR_DATA);
  assign rst_cfg = wr_rst
                 & (wr_hi == wit_pkg::KEY_RST_CFG);

  // Read address decoding
  assign rd_ctrl = rd_byte
                 & (bus_req_i.addr == wit_pkg::ADDR_CTRL_RD);
  assign rd_count = rd_byte
                  & (bus_req_i.addr == wit_pkg::ADDR_COUNT_RD);
  assign rd_rst = rd_byte
                & (bus_req_i.addr == wit_pkg::ADDR_RST_RD);

  // Prescaler tap and counter wrap; a write to the counter wins
  assign tick = ((pre_ff & tap_mask(prescale_select_ff))
              == tap_mask(prescale_select_ff));
  assign wrap = timer_run_enable_ff & tick & ~cnt_load
              & (timer_count_ff == wit_pkg::COUNT_TOP);
  assign iv_wrap = wrap
                 & (timer_mode_select_ff == wit_pkg::MODE_INTERVAL);
  assign wd_wrap = wrap
                 & (timer_mode_select_ff == wit_pkg::MODE_WATCHDOG);

  // Read data multiplexer with reserved bits forced to one
  always_comb begin
    nxt_rdata = 8'h00;
    if (rd_ctrl) begin
      nxt_rdata = wit_pkg::CTRL_RESV_ONES;
      nxt_rdata[wit_pkg::CTRL_FLAG_BIT] = interval_overflow_flag_ff;
      nxt_rdata[wit_pkg::CTRL_MODE_BIT] = timer_mode_select_ff;
      nxt_rdata[wit_pkg::CTRL_RUN_BIT] = timer_run_enable_ff;
      nxt_rdata[wit_pkg::CTRL_SEL_LSB +: 3] = prescale_select_ff;
    end else if (rd_count) begin
      nxt_rdata = timer_count_ff;
    end else if (rd_rst) begin
      nxt_rdata = wit_pkg::RST_RESV_ONES;
      nxt_rdata[wit_pkg::RST_FLAG_BIT] = watchdog_overflow_flag_ff;
      nxt_rdata[wit_pkg::RST_ENA_BIT] = chip_reset_enable_ff;
      nxt_rdata[wit_pkg::RST_TYPE_BIT] = chip_reset_type_ff;
    end
  end

  // Bus answer one cycle after every request
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rsp_ff <= '0;
    end else begin
      rsp_ff.ack <= bus_req_i.valid;
      rsp_ff.rdata <= nxt_rdata;
    end
  end

  // Free-running prescaler of the system clock
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pre_ff <= '0;
    end else begin
      pre_ff <= pre_ff + 13'h0001;
    end
  end

  // Control register: mode, run enable and clock select
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      timer_mode_select_ff <= wit_pkg::MODE_INTERVAL;
      timer_run_enable_ff <= 1'b0;
      prescale_select_ff <= wit_pkg::SEL_RESET;
    end else if (standby_entry_i) begin
      timer_mode_select_ff <= wit_pkg::MODE_INTERVAL;
      timer_run_enable_ff <= 1'b0;
    end else if (wd_wrap) begin
      timer_mode_select_ff <= wit_pkg::MODE_INTERVAL;
      timer_run_enable_ff <= 1'b0;
      prescale_select_ff <= wit_pkg::SEL_RESET;
    end else if (ctrl_load) begin
      timer_mode_select_ff <=
        wit_pkg::wit_mode_e'(wr_lo[wit_pkg::CTRL_MODE_BIT]);
      timer_run_enable_ff <= wr_lo[wit_pkg::CTRL_RUN_BIT];
      prescale_select_ff <= wr_lo[wit_pkg::CTRL_SEL_LSB +: 3];
    end
  end

  // Interval flag: set wins; clear needs an earlier read as one
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      interval_overflow_flag_ff <= 1'b0;
    end else if (iv_wrap) begin
      interval_overflow_flag_ff <= 1'b1;
    end else if (standby_entry_i) begin
      interval_overflow_flag_ff <= 1'b0;
    end else if (ctrl_load & ovf_armed_ff
                 & ~wr_lo[wit_pkg::CTRL_FLAG_BIT]) begin
      interval_overflow_flag_ff <= 1'b0;
    end
  end

  // Arm the interval flag clear when software has seen it set
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ovf_armed_ff <= 1'b0;
    end else if (standby_entry_i | ~interval_overflow_flag_ff) begin
      ovf_armed_ff <= 1'b0;
    end else if (ctrl_load & ~wr_lo[wit_pkg::CTRL_FLAG_BIT]) begin
      ovf_armed_ff <= 1'b0;
    end else if (rd_ctrl) begin
      ovf_armed_ff <= 1'b1;
    end
  end

  // Counter: held at zero while stopped, write beats increment
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      timer_count_ff <= wit_pkg::COUNT_RESET;
    end else if (wd_wrap | ~timer_run_enable_ff) begin
      timer_count_ff <= wit_pkg::COUNT_RESET;
    end else if (cnt_load) begin
      timer_count_ff <= wr_lo;
    end else if (tick) begin
      timer_count_ff <= timer_count_ff + 8'h01;
    end
  end

  // Watchdog flag: set wins; clear needs an earlier read as one
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      watchdog_overflow_flag_ff <= 1'b0;
    end else if (wd_wrap) begin
      watchdog_overflow_flag_ff <= 1'b1;
    end else if (standby_entry_i) begin
      watchdog_overflow_flag_ff <= 1'b0;
    end else if (rst_clr & watchdog_overflow_flag_armed_ff) begin
      watchdog_overflow_flag_ff <= 1'b0;
    end
  end

  // Arm the watchdog flag clear when software has seen it set
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      watchdog_overflow_flag_armed_ff <= 1'b0;
    end else if (standby_entry_i | ~watchdog_overflow_flag_ff) begin
      watchdog_overflow_flag_armed_ff <= 1'b0;
    end else if (rst_clr) begin
      watchdog_overflow_flag_armed_ff <= 1'b0;
    end else if (rd_rst) begin
      watchdog_overflow_flag_armed_ff <= 1'b1;
    end
  end

  // Reset enable and type; untouched by the watchdog's own reset
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      chip_reset_enable_ff <= 1'b0;
      chip_reset_type_ff <= 1'b0;
    end else if (standby_entry_i) begin
      chip_reset_enable_ff <= 1'b0;
      chip_reset_type_ff <= 1'b0;
    end else if (rst_cfg) begin
      chip_reset_enable_ff <= wr_lo[wit_pkg::RST_ENA_BIT];
      chip_reset_type_ff <= wr_lo[wit_pkg::RST_TYPE_BIT];
    end
  end

  // Overflow pin held low for a fixed count after a watchdog wrap
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ovo_n_ff <= 1'b1;
      ovo_cnt_ff <= '0;
    end else if (wd_wrap) begin
      ovo_n_ff <= 1'b0;
      ovo_cnt_ff <= 7'(wit_pkg::OVF_PULSE_CYCLES - 1);
    end else if (!ovo_n_ff) begin
      if (ovo_cnt_ff == 7'h00) begin
        ovo_n_ff <= 1'b1;
      end else begin
        ovo_cnt_ff <= ovo_cnt_ff - 7'h01;
      end
    end
  end

  // Internal chip reset of the selected type, fixed length
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      crst_ff <= '0;
      crst_cnt_ff <= '0;
    end else if (wd_wrap & chip_reset_enable_ff) begin
      crst_ff.power_on <= ~chip_reset_type_ff;
      crst_ff.manual <= chip_reset_type_ff;
      crst_cnt_ff <= 9'(wit_pkg::CHIP_RST_CYCLES - 1);
    end else if (crst_ff.power_on | crst_ff.manual) begin
      if (crst_cnt_ff == 9'h000) begin
        crst_ff <= '0;
      end else begin
        crst_cnt_ff <= crst_cnt_ff - 9'h001;
      end
    end
  end

  // Outputs straight from flip-flops
  assign interval_irq_o = interval_overflow_flag_ff;
  assign overflow_out_n_o = ovo_n_ff;
  assign chip_rst_o = crst_ff;
  assign bus_rsp_o = rsp_ff;

endmodule : wit_timer

// *** wit_timer_asserts.sv ***
// Port checker for the watchdog and interval timer block.
// Assumes one clock domain; bound to every wit_timer.
`timescale 1ns/10ps
module wit_timer_asserts (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Inputs
  input wire logic standby_entry_i,
  input wire wit_pkg::wit_bus_req_s bus_req_i,
  // Outputs
  input wire wit_pkg::wit_bus_rsp_s bus_rsp_o,
  input wire logic interval_irq_o,
  input wire logic overflow_out_n_o,
  input wire wit_pkg::wit_chip_rst_s chip_rst_o
);
  logic [9:0] low_ff;
  logic [9:0] crst_ff;
  logic crst;
  assign crst = chip_rst_o.power_on | chip_rst_o.manual;
  // Cycles spent with the overflow pin low
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) low_ff <= 10'h000;
    else low_ff <= overflow_out_n_o ? 10'h000 : low_ff + 10'h001;
  end
  // Cycles spent with a chip reset request high
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) crst_ff <= 10'h000;
    else crst_ff <= crst ? crst_ff + 10'h001 : 10'h000;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // Byte read taken at the given address
  sequence s_rd(logic [27:0] a);
    bus_req_i.valid && !bus_req_i.write && !bus_req_i.word &&
    bus_req_i.addr == a;
  endsequence
  property p_ack; bus_req_i.valid |=> bus_rsp_o.ack; endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  property p_wr_zero;
    bus_req_i.valid && bus_req_i.write |=> bus_rsp_o.rdata == 8'h00;
  endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("write data");
  property p_resv_ctrl;
    s_rd(wit_pkg::ADDR_CTRL_RD) |=> bus_rsp_o.rdata[4:3] == 2'h3;
  endproperty
  a_resv_ctrl: assert property (p_resv_ctrl) else $error("ctrl ones");
  property p_resv_rst;
    s_rd(wit_pkg::ADDR_RST_RD) |=> bus_rsp_o.rdata[4:0] == 5'h1F;
  endproperty
  a_resv_rst: assert property (p_resv_rst) else $error("rst ones");
  property p_flag_irq;
    s_rd(wit_pkg::ADDR_CTRL_RD) |=>
      bus_rsp_o.rdata[7] == $past(interval_irq_o);
  endproperty
  a_flag_irq: assert property (p_flag_irq) else $error("flag irq");
  property p_ovf_len; $rose(overflow_out_n_o) |-> low_ff == 10'd128;
  endproperty
  a_ovf_len: assert property (p_ovf_len) else $error("pin length");
  property p_crst_len; $fell(crst) |-> crst_ff == 10'd512; endproperty
  a_crst_len: assert property (p_crst_len) else $error("crst length");
  property p_crst_sync; $rose(crst) |-> $fell(overflow_out_n_o);
  endproperty
  a_crst_sync: assert property (p_crst_sync) else $error("crst sync");
  property p_type; !(chip_rst_o.power_on && chip_rst_o.manual);
  endproperty
  a_type: assert property (p_type) else $error("two types");
  property p_irq_mode;
    $rose(interval_irq_o) |-> overflow_out_n_o && !crst;
  endproperty
  a_irq_mode: assert property (p_irq_mode) else $error("irq mode");
endmodule : wit_timer_asserts

bind wit_timer wit_timer_asserts chk_u (.clk_i, .nrst_i,
  .standby_entry_i, .bus_req_i, .bus_rsp_o, .interval_irq_o,
  .overflow_out_n_o, .chip_rst_o);
